// [station_cfg_consts.svh]
`ifndef STATION_CFG_CONSTS_SVH
`define STATION_CFG_CONSTS_SVH
// register byte addresses
`define REG_CFG_STATUS   8'h00
`define REG_NET_STORED   8'h04
`define REG_IRQ_STATUS   8'h08
`define REG_IRQ_MASK     8'h0C
`define REG_FAULT_CTRL   8'h10
`define REG_VALVE_CMD    8'h14
`define REG_VALVE_OUT    8'h18
// dip bank bit positions
`define DIP_NET_A        0
`define DIP_NET_B        1
`define DIP_HOLD         2
// station and network number limits
`define STATION_MIN      7'h01
`define STATION_MAX      7'h78
`define NET_MIN          8'h01
`define NET_MAX          8'hEF
// irq bit positions
`define IRQ_STATION_BAD  0
`define IRQ_NET_BAD      1
`define IRQ_FAULT_ENTER  2
// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [station_cfg_pkg.sv]
package station_cfg_pkg;
  typedef enum logic [1:0] {
    NET_FROM_STORE = 2'h0,
    NET_ONE        = 2'h1,
    NET_TWO        = 2'h2,
    NET_THREE      = 2'h3
  } netMode_t;
  typedef enum logic [1:0] {
    LD_WAIT   = 2'h0,
    LD_SAMPLE = 2'h1,
    LD_RUN    = 2'h2
  } loadState_t;
endpackage

// [station_number_decode.sv]
`timescale 1ns/1ps
`include "station_cfg_consts.svh"
module station_number_decode (
  // switch digits
  input  wire logic [3:0] tensDigit,
  input  wire logic [3:0] unitsDigit,
  // decoded result
  output logic      [6:0] stationNumber,
  output logic            stationValid
);
  logic [6:0] tensValue;

  always_comb begin
    tensValue = 7'h00;
    if (tensDigit <= 4'hC) begin
      tensValue = 7'(tensDigit) * 7'h0A;
    end
  end

  always_comb begin
    stationNumber = 7'(tensValue + 7'(unitsDigit));
    stationValid  = (tensDigit <= 4'hC) && (unitsDigit <= 4'h9)
                 && (stationNumber >= `STATION_MIN) && (stationNumber <= `STATION_MAX);
  end
endmodule

// [station_switch_config_decoder.sv]
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "station_cfg_consts.svh"
module station_switch_config_decoder (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // configuration switches
  input  wire logic [5:0]  dip_config_switch_bank,
  input  wire logic [3:0]  station_tens_digit_switch,
  input  wire logic [3:0]  station_units_digit_switch,
  // link status
  input  wire logic        linkCommError,
  input  wire logic        linkIdle,
  // decoded configuration, valve outputs and interrupt
  output logic      [7:0]  networkNumber,
  output logic      [6:0]  stationNumber,
  output logic             configReady,
  output logic             netErrorLed,
  output logic      [31:0] valveOut,
  output logic             irq,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // switch and link synchronisers
  logic [13:0] swMeta_q;
  logic [13:0] swSync_q;
  logic [1:0]  linkMeta_q;
  logic [1:0]  linkSync_q;
  logic        linkFault;
  logic        linkFaultDly_q;

  // no reset: the pair keeps filling while reset is held
  always_ff @(posedge mclk) begin
    swMeta_q <= {dip_config_switch_bank, station_tens_digit_switch,
                 station_units_digit_switch};
    swSync_q <= swMeta_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linkMeta_q     <= 2'h0;
      linkSync_q     <= 2'h0;
      linkFaultDly_q <= 1'b0;
    end else begin
      linkMeta_q     <= {linkCommError, linkIdle};
      linkSync_q     <= linkMeta_q;
      linkFaultDly_q <= linkFault;
    end
  end

  assign linkFault = linkSync_q[1] || linkSync_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // power-up sampling
  station_cfg_pkg::loadState_t loadState_q;
  logic       cfgDone_q;
  logic [5:0] dipLatched_q;
  logic [3:0] tensLatched_q;
  logic [3:0] unitsLatched_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loadState_q <= station_cfg_pkg::LD_WAIT;
      cfgDone_q   <= 1'b0;
    end else begin
      cfgDone_q   <= configReady;
      case (loadState_q)
        station_cfg_pkg::LD_WAIT:   loadState_q <= station_cfg_pkg::LD_SAMPLE;
        station_cfg_pkg::LD_SAMPLE: loadState_q <= station_cfg_pkg::LD_RUN;
        station_cfg_pkg::LD_RUN:    loadState_q <= station_cfg_pkg::LD_RUN;
        default:                    loadState_q <= station_cfg_pkg::LD_WAIT;
      endcase
    end
  end

  // wait state lets the synchronisers fill before the one capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dipLatched_q   <= 6'h00;
      tensLatched_q  <= 4'h0;
      unitsLatched_q <= 4'h0;
    end else if (loadState_q == station_cfg_pkg::LD_SAMPLE) begin
      dipLatched_q   <= swSync_q[13:8];
      tensLatched_q  <= swSync_q[7:4];
      unitsLatched_q <= swSync_q[3:0];
    end
  end

  assign configReady = (loadState_q == station_cfg_pkg::LD_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // network and station decode
  station_cfg_pkg::netMode_t netMode;
  logic [7:0] netStored_q;
  logic       stationValid;
  logic       netValid;

  assign netMode = station_cfg_pkg::netMode_t'({dipLatched_q[`DIP_NET_B],
                                                dipLatched_q[`DIP_NET_A]});

  always_comb begin
    case (netMode)
      station_cfg_pkg::NET_ONE:   networkNumber = 8'h01;
      station_cfg_pkg::NET_TWO:   networkNumber = 8'h02;
      station_cfg_pkg::NET_THREE: networkNumber = 8'h03;
      default:                    networkNumber = netStored_q;
    endcase
  end

  assign netValid = (networkNumber >= `NET_MIN) && (networkNumber <= `NET_MAX);

  station_number_decode u_decode (
    .tensDigit     (tensLatched_q),
    .unitsDigit    (unitsLatched_q),
    .stationNumber (stationNumber),
    .stationValid  (stationValid)
  );

  assign netErrorLed = configReady && (!stationValid || !netValid);

  ////////////////////////////////////////////////////////////////////////////
  // fault output behaviour
  logic [31:0] valveCmd_q;
  logic [31:0] valveOut_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valveOut_q <= 32'h00000000;
    end else if (!configReady) begin
      valveOut_q <= 32'h00000000;
    end else if (linkFault) begin
      if (!dipLatched_q[`DIP_HOLD]) begin
        valveOut_q <= 32'h00000000;
      end
    end else begin
      valveOut_q <= valveCmd_q;
    end
  end

  assign valveOut = valveOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events
  logic [2:0] irqStatus_q;
  logic [2:0] irqMask_q;
  logic [2:0] irqClear;
  logic [2:0] irqSet;

  // load checks fire once, on the first ready cycle
  assign irqSet = {linkFault && !linkFaultDly_q && configReady,
                   configReady && !cfgDone_q && !netValid,
                   configReady && !cfgDone_q && !stationValid};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= 3'h0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~irqClear) | irqSet;
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [7:0]  awAddr_q;
  logic        awHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wHeld_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic        doWrite;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign doWrite       = awHeld_q && wHeld_q && !bValid_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        case (awAddr_q)
          `REG_NET_STORED, `REG_IRQ_STATUS, `REG_IRQ_MASK, `REG_VALVE_CMD:
            bResp_q <= `RESP_OKAY;
          default: bResp_q <= `RESP_SLVERR;
        endcase
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  assign irqClear = (doWrite && awAddr_q == `REG_IRQ_STATUS && wStrb_q[0])
                    ? wData_q[2:0] : 3'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      netStored_q <= 8'h00;
      irqMask_q   <= 3'h0;
      valveCmd_q  <= 32'h00000000;
    end else if (doWrite) begin
      if (awAddr_q == `REG_NET_STORED && wStrb_q[0]) begin
        netStored_q <= wData_q[7:0];
      end
      if (awAddr_q == `REG_IRQ_MASK && wStrb_q[0]) begin
        irqMask_q <= wData_q[2:0];
      end
      if (awAddr_q == `REG_VALVE_CMD) begin
        for (int i = 0; i < 4; i++) begin
          if (wStrb_q[i]) begin
            valveCmd_q[i*8 +: 8] <= wData_q[i*8 +: 8];
          end
        end
      end
    end
  end

  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = !rValid_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_q <= 1'b1;
      rResp_q  <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CFG_STATUS: rData_q <= {4'h0, dipLatched_q[3:0], tensLatched_q,
                                     unitsLatched_q, 1'b0, stationNumber,
                                     networkNumber[3:0], netErrorLed,
                                     dipLatched_q[`DIP_HOLD], configReady,
                                     linkFault};
        `REG_NET_STORED: rData_q <= {24'h000000, netStored_q};
        `REG_IRQ_STATUS: rData_q <= {29'h00000000, irqStatus_q};
        `REG_IRQ_MASK:   rData_q <= {29'h00000000, irqMask_q};
        `REG_FAULT_CTRL: rData_q <= {24'h000000, networkNumber};
        `REG_VALVE_CMD:  rData_q <= valveCmd_q;
        `REG_VALVE_OUT:  rData_q <= valveOut_q;
        default: begin
          rData_q <= 32'h00000000;
          rResp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata  = rData_q;
  assign s_axi_rresp  = rResp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_clearOnFault;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && linkFault && !dipLatched_q[`DIP_HOLD]) |=> (valveOut == 32'h00000000);
  endproperty
  a_clearOnFault: assert property (p_clearOnFault) else $error("outputs not cleared");
  property p_holdOnFault;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && linkFault && dipLatched_q[`DIP_HOLD]) |=> $stable(valveOut);
  endproperty
  a_holdOnFault: assert property (p_holdOnFault) else $error("outputs not held");
  property p_frozenSwitches;
    @(posedge mclk) disable iff (!rst_n)
      configReady |=> $stable(dipLatched_q) && $stable(tensLatched_q);
  endproperty
  a_frozenSwitches: assert property (p_frozenSwitches) else $error("switches resampled");
  property p_stationRange;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && (stationNumber == 7'h00 || stationNumber > 7'h78)) |-> netErrorLed;
  endproperty
  a_stationRange: assert property (p_stationRange) else $error("bad station no error");
  property p_badDigit;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && (unitsLatched_q > 4'h9 || tensLatched_q > 4'hC)) |-> netErrorLed;
  endproperty
  a_badDigit: assert property (p_badDigit) else $error("bad digit no error");
  property p_stationSum;
    @(posedge mclk) disable iff (!rst_n)
      (tensLatched_q <= 4'hC && unitsLatched_q <= 4'h9) |->
        stationNumber == 7'(tensLatched_q) * 7'h0A + 7'(unitsLatched_q);
  endproperty
  a_stationSum: assert property (p_stationSum) else $error("station sum wrong");
  property p_fixedNet;
    @(posedge mclk) disable iff (!rst_n)
      (netMode != station_cfg_pkg::NET_FROM_STORE) |-> networkNumber == 8'(netMode);
  endproperty
  a_fixedNet: assert property (p_fixedNet) else $error("network number wrong");
  property p_netUnset;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && netMode == station_cfg_pkg::NET_FROM_STORE && netStored_q == 8'h00)
        |-> netErrorLed;
  endproperty
  a_netUnset: assert property (p_netUnset) else $error("unset network no error");
  property p_goodConfig;
    @(posedge mclk) disable iff (!rst_n)
      (configReady && stationNumber inside {[7'h01:7'h78]} && unitsLatched_q <= 4'h9
       && tensLatched_q <= 4'hC && networkNumber inside {[8'h01:8'hEF]}) |-> !netErrorLed;
  endproperty
  a_goodConfig: assert property (p_goodConfig) else $error("false network error");
endmodule

// [station_switch_config_decoder_tb_top.sv]
`timescale 1ns/1ps
`include "station_cfg_consts.svh"
module station_switch_config_decoder_tb_top;
  logic        mclk, rst_n, linkCommError, linkIdle, configReady, netErrorLed, irq;
  logic [5:0]  dipBank;
  logic [3:0]  tensDigit, unitsDigit, wstrb;
  logic [7:0]  networkNumber, awaddr, araddr;
  logic [6:0]  stationNumber;
  logic [31:0] valveOut, wdata, rdata, rdVal;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rsp;
  int          num_errors, checked;

  switch_panel_model u_switch_panel_model (
    .dipBank(dipBank), .tensDigit(tensDigit), .unitsDigit(unitsDigit));

  station_switch_config_decoder u_station_switch_config_decoder (
    .mclk(mclk), .rst_n(rst_n), .dip_config_switch_bank(dipBank),
    .station_tens_digit_switch(tensDigit), .station_units_digit_switch(unitsDigit),
    .linkCommError(linkCommError), .linkIdle(linkIdle), .networkNumber(networkNumber),
    .stationNumber(stationNumber), .configReady(configReady), .netErrorLed(netErrorLed),
    .valveOut(valveOut), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic giveUp(input string name);
    num_errors++;
    $display("mismatch %s expected handshake seen none", name);
    end_of_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1 || wvalid && wready !== 1'b1) && n < 99);
    while (bvalid !== 1'b1 && n < 99) begin
      @(posedge mclk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    if (n >= 99) giveUp("bvalid");
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (arready !== 1'b1 && n < 99);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 99) begin
      @(posedge mclk);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 99) giveUp("rvalid");
  endtask

  // power cycle with new switch settings
  task automatic powerUp(input logic [2:0] dip, input logic [3:0] tens, input logic [3:0] units);
    int n;
    @(posedge mclk);
    rst_n <= 1'b0;
    u_switch_panel_model.setAll(dip, tens, units);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (configReady !== 1'b1 && n < 20);
    if (n >= 20) giveUp("configReady");
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic testNetwork();
    for (int m = 1; m < 4; m++) begin
      powerUp(3'(m), 4'h1, 4'h0);
      check("network", 32'(networkNumber), 32'(m));
      check("errLed", 32'(netErrorLed), 32'h0);
    end
    powerUp(3'h0, 4'h1, 4'h0);
    check("errLed", 32'(netErrorLed), 32'h1);
    axiRead(`REG_IRQ_STATUS, rdVal, rsp);
    check("irqStatus", rdVal, 32'h2);
    axiRead(`REG_NET_STORED, rdVal, rsp);
    check("netStored", rdVal, 32'h0);
    axiRead(`REG_IRQ_MASK, rdVal, rsp);
    check("irqMask", rdVal, 32'h0);
    axiWrite(`REG_NET_STORED, 32'hEF, rsp);
    @(posedge mclk);
    check("network", 32'(networkNumber), 32'hEF);
  endtask

  task automatic testStation();
    logic [3:0] t [9] = '{4'h0, 4'h0, 4'h1, 4'h9, 4'hA, 4'hB, 4'hC, 4'hC, 4'hD};
    logic [3:0] u [9] = '{4'h0, 4'h1, 4'hA, 4'h9, 4'h9, 4'h1, 4'h0, 4'h1, 4'h0};
    int e;
    logic ok;
    for (int i = 0; i < 9; i++) begin
      e = (t[i] > 4'hC || u[i] > 4'h9) ? 0 : t[i] * 10 + u[i];
      ok = e >= 1 && e <= 120;
      powerUp(3'h1, t[i], u[i]);
      check("errLed", 32'(netErrorLed), 32'(!ok));
      if (ok) check("station", 32'(stationNumber), 32'(e));
      check("irq", 32'(irq), 32'h0);
      axiRead(`REG_IRQ_STATUS, rdVal, rsp);
      check("irqStatus", rdVal, 32'(!ok));
    end
  endtask

  task automatic testLatch();
    powerUp(3'h2, 4'h5, 4'h5);
    u_switch_panel_model.setAll(3'h1, 4'hD, 4'hF);
    repeat (8) @(posedge mclk);
    check("station", 32'(stationNumber), 32'h37);
    check("network", 32'(networkNumber), 32'h2);
    check("errLed", 32'(netErrorLed), 32'h0);
    axiRead(`REG_CFG_STATUS, rdVal, rsp);
    check("cfgStatus", rdVal, 32'h02553722);
    axiRead(`REG_FAULT_CTRL, rdVal, rsp);
    check("netReg", rdVal, 32'h2);
  endtask

  task automatic testFault(input logic hold);
    logic [31:0] cmd;
    cmd = hold ? 32'hA55A0FF0 : 32'h5AC3F00F;
    powerUp({hold, 2'h1}, 4'h1, 4'h0);
    axiWrite(`REG_IRQ_MASK, 32'h4, rsp);
    axiWrite(`REG_VALVE_CMD, cmd, rsp);
    repeat (3) @(posedge mclk);
    check("valveOut", valveOut, cmd);
    linkCommError <= !hold;
    linkIdle <= hold;
    repeat (5) @(posedge mclk);
    axiWrite(`REG_VALVE_CMD, 32'h0000FFFF, rsp);
    repeat (3) @(posedge mclk);
    check("valveOut", valveOut, hold ? cmd : 32'h0);
    check("irq", 32'(irq), 32'h1);
    axiRead(`REG_IRQ_STATUS, rdVal, rsp);
    check("irqStatus", rdVal, 32'h4);
    axiRead(`REG_VALVE_OUT, rdVal, rsp);
    check("valveReg", rdVal, hold ? cmd : 32'h0);
    linkCommError <= 1'b0;
    linkIdle <= 1'b0;
    repeat (5) @(posedge mclk);
    check("valveOut", valveOut, 32'h0000FFFF);
    axiWrite(`REG_IRQ_STATUS, 32'h4, rsp);
    repeat (2) @(posedge mclk);
    check("irq", 32'(irq), 32'h0);
  endtask

  task automatic testBus();
    axiRead(8'h40, rdVal, rsp);
    check("rresp", 32'(rsp), 32'(`RESP_SLVERR));
    check("rdata", rdVal, 32'h0);
    axiWrite(8'h44, 32'h1, rsp);
    check("bresp", 32'(rsp), 32'(`RESP_SLVERR));
    axiWrite(`REG_CFG_STATUS, 32'hFFFFFFFF, rsp);
    check("bresp", 32'(rsp), 32'(`RESP_SLVERR));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    linkCommError = 1'b0;
    linkIdle = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    num_errors = 0;
    checked = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    testNetwork();
    testStation();
    testLatch();
    testFault(1'b0);
    testFault(1'b1);
    testBus();
    end_of_test();
  end
endmodule

// [switch_panel_model.sv]
`timescale 1ns/1ps
module switch_panel_model (
  // switch levels
  output logic [5:0] dipBank,
  output logic [3:0] tensDigit,
  output logic [3:0] unitsDigit
);
  initial begin
    dipBank = 6'h00;
    tensDigit = 4'h1;
    unitsDigit = 4'h0;
  end
  // reserved positions always left off
  task automatic setAll(input logic [2:0] dip, input logic [3:0] tens, input logic [3:0] units);
    dipBank <= {3'h0, dip};
    tensDigit <= tens;
    unitsDigit <= units;
  endtask
endmodule
